// ==== hw/idm_exec.sv ====
`timescale 1ns/1ps
// How it works
// [RULE1] SIMD premod: X at I+imm, Y adds k
// [RULE2] Premodified transfer never writes index back
// [RULE3] Software keeps ureg off the access's generator
// [RULE4] SIMD: X uses ureg, Y its complement
// [RULE5] Uncomplemented registers act as single stream
// [RULE6] Memory immediate fills upper 32, low 8 zero
// [RULE7] Memory immediate addresses I, then I+=M
// [RULE8] SIMD memory write: X at I, Y I+k
// [RULE9] k is 1 normal, 2 short, 0 broadcast
// [RULE10] X and Y accesses issue together
// [RULE11] Short form carries 16-bit immediate
// [RULE12] Register immediate: 40-bit target gets zero pad
// [RULE13] SIMD register immediate also loads complement
// [RULE14] Length from format: 48, 32, 16 bits
// [RULE15] Modifier is full 32-bit unsigned quantity
// [RULE16] Long-word qualifier forces long-word access
// [RULE17] Premod sum formed same cycle, wraps
// [RULE18] No complement means no Y access
module idm_exec
	import idm_pkg::*;
(
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  clk_en_i,
	input  wire idm_instr_t            instr_i,
	input  wire logic                  simd_i,
	input  wire logic                  broadcast_i,
	input  wire logic                  short_word_i,
	input  wire logic [ADDR_W-1:0]     index_data_i,
	input  wire logic [ADDR_W-1:0]     modify_data_i,
	output idm_mem_t                   mem_x_o,
	output idm_mem_t                   mem_y_o,
	output idm_reg_t                   reg_x_o,
	output idm_reg_t                   reg_y_o,
	output logic                       idx_wr_o,
	output logic [IDX_SEL_W-1:0]       idx_wr_sel_o,
	output logic                       idx_wr_pm_o,
	output logic [ADDR_W-1:0]          idx_wr_data_o,
	output logic [5:0]                 instr_len_o,
	output logic                       illegal_o
);
	import idm_pkg::*;

	idm_mem_t          mem_x_reg;
	idm_mem_t          mem_y_reg;
	idm_mem_t          mem_x_next;
	idm_mem_t          mem_y_next;
	idm_reg_t          reg_x_reg;
	idm_reg_t          reg_y_reg;
	idm_reg_t          reg_x_next;
	idm_reg_t          reg_y_next;
	logic              idx_wr_reg;
	logic              idx_wr_next;
	logic [IDX_SEL_W-1:0] idx_sel_reg;
	logic              idx_pm_reg;
	logic [ADDR_W-1:0] idx_data_reg;
	logic [ADDR_W-1:0] idx_data_next;
	logic [5:0]        len_reg;
	logic [5:0]        len_next;
	logic              illegal_reg;
	logic              illegal_next;
	logic [IMM_W-1:0]  imm_eff;
	logic [WORD_W-1:0] imm_word;
	logic [ADDR_W-1:0] base_addr;
	logic [ADDR_W-1:0] y_addr;
	logic              has_cpl;
	logic              y_on;
	logic              same_gen;

	// The short form holds only 16 bits of immediate; upper bits are ignored.
	always_comb begin
		if (instr_i.fmt == IDM_FMT_A) begin
			imm_eff = instr_i.imm; // [RULE15]
		end else begin
			imm_eff = {{(IMM_W-SHORT_IMM_W){1'b0}}, instr_i.imm[SHORT_IMM_W-1:0]}; // [RULE11]
		end
	end

	assign imm_word = {imm_eff, {PAD_W{1'b0}}}; // [RULE6]

	// Premodified forms add the immediate; post-modify forms use the index alone.
	always_comb begin
		if (instr_i.op == IDM_OP_PREMOD_RD || instr_i.op == IDM_OP_PREMOD_WR) begin
			base_addr = index_data_i + imm_eff; // [RULE17]
		end else begin
			base_addr = index_data_i; // [RULE7]
		end
	end

	idm_skew u_skew (
		.simd_i       (simd_i),
		.broadcast_i  (broadcast_i),
		.short_word_i (short_word_i),
		.base_i       (base_addr),
		.y_addr_o     (y_addr)
	);

	assign has_cpl  = instr_i.ureg[CPL_BIT];
	assign y_on     = simd_i && has_cpl; // [RULE5]
	// Index registers sit in codes 0..15; bit 3 picks the program-side generator.
	assign same_gen = (instr_i.ureg[UREG_W-1:4] == 3'h0) && (instr_i.ureg[3] == instr_i.pm_space);

	always_comb begin
		mem_x_next    = '0;
		mem_y_next    = '0;
		reg_x_next    = '0;
		reg_y_next    = '0;
		idx_wr_next   = 1'b0;
		idx_data_next = idx_data_reg;
		illegal_next  = 1'b0;
		if (instr_i.valid) begin
			case (instr_i.op)
				IDM_OP_PREMOD_RD,
				IDM_OP_PREMOD_WR: begin
					illegal_next         = same_gen; // [RULE3]
					mem_x_next.en        = 1'b1;
					mem_x_next.wr        = (instr_i.op == IDM_OP_PREMOD_WR);
					mem_x_next.pm_space  = instr_i.pm_space;
					mem_x_next.long_word = instr_i.long_word; // [RULE16]
					mem_x_next.addr      = base_addr; // [RULE1]
					mem_y_next           = mem_x_next;
					mem_y_next.en        = y_on; // [RULE10] [RULE18]
					mem_y_next.addr      = y_addr; // [RULE1]
					if (instr_i.op == IDM_OP_PREMOD_RD) begin
						reg_x_next.sel = instr_i.ureg; // [RULE4]
						reg_y_next.sel = instr_i.ureg ^ CPL_FLIP; // [RULE4]
					end
					// Index stays put; no write-back is raised here. [RULE2]
				end
				IDM_OP_IMM_MEM: begin
					mem_x_next.en       = 1'b1;
					mem_x_next.wr       = 1'b1;
					mem_x_next.pm_space = instr_i.pm_space;
					mem_x_next.addr     = base_addr; // [RULE8]
					mem_x_next.wdata    = imm_word; // [RULE6]
					mem_y_next          = mem_x_next;
					mem_y_next.en       = simd_i; // [RULE8] [RULE10]
					mem_y_next.addr     = y_addr; // [RULE8]
					idx_wr_next         = 1'b1;
					idx_data_next       = index_data_i + modify_data_i; // [RULE7]
				end
				IDM_OP_IMM_REG: begin
					reg_x_next.en   = 1'b1;
					reg_x_next.sel  = instr_i.ureg;
					reg_x_next.data = instr_i.reg40 ? imm_word : {{PAD_W{1'b0}}, imm_eff}; // [RULE12]
					reg_y_next      = reg_x_next;
					reg_y_next.en   = y_on; // [RULE13] [RULE18]
					reg_y_next.sel  = instr_i.ureg ^ CPL_FLIP; // [RULE13]
				end
				default: begin
					illegal_next = (instr_i.op != IDM_OP_NONE);
				end
			endcase
		end
	end

	always_comb begin
		case (instr_i.fmt)
			IDM_FMT_A: len_next = LEN_A; // [RULE14]
			IDM_FMT_B: len_next = LEN_B; // [RULE14]
			IDM_FMT_C: len_next = LEN_C; // [RULE14]
			default:   len_next = LEN_A;
		endcase
	end

	// Both elements register on the same edge so their accesses stay aligned.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mem_x_reg <= '0;
			mem_y_reg <= '0;
		end else if (clk_en_i) begin
			mem_x_reg <= mem_x_next; // [RULE10]
			mem_y_reg <= mem_y_next; // [RULE10]
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_x_reg <= '0;
			reg_y_reg <= '0;
		end else if (clk_en_i) begin
			reg_x_reg <= reg_x_next;
			reg_y_reg <= reg_y_next;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idx_wr_reg   <= 1'b0;
			idx_sel_reg  <= '0;
			idx_pm_reg   <= 1'b0;
			idx_data_reg <= '0;
		end else if (clk_en_i) begin
			idx_wr_reg   <= idx_wr_next;
			idx_sel_reg  <= instr_i.idx_sel;
			idx_pm_reg   <= instr_i.pm_space;
			idx_data_reg <= idx_data_next;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			len_reg     <= '0;
			illegal_reg <= 1'b0;
		end else if (clk_en_i) begin
			len_reg     <= instr_i.valid ? len_next : 6'h00;
			illegal_reg <= illegal_next;
		end
	end

	assign mem_x_o       = mem_x_reg;
	assign mem_y_o       = mem_y_reg;
	assign reg_x_o       = reg_x_reg;
	assign reg_y_o       = reg_y_reg;
	assign idx_wr_o      = idx_wr_reg;
	assign idx_wr_sel_o  = idx_sel_reg;
	assign idx_wr_pm_o   = idx_pm_reg;
	assign idx_wr_data_o = idx_data_reg;
	assign instr_len_o   = len_reg;
	assign illegal_o     = illegal_reg;

endmodule : idm_exec

// ==== hw/idm_pkg.sv ====
package idm_pkg;

	localparam int ADDR_W      = 32;
	localparam int WORD_W      = 40;
	localparam int IMM_W       = 32;
	localparam int PAD_W       = 8;
	localparam int SHORT_IMM_W = 16;
	localparam int UREG_W      = 7;
	localparam int IDX_SEL_W   = 3;

	// Y-element skew values.
	localparam logic [31:0] SKEW_BCAST  = 32'h0000_0000;
	localparam logic [31:0] SKEW_NORMAL = 32'h0000_0001;
	localparam logic [31:0] SKEW_SHORT  = 32'h0000_0002;

	// Instruction lengths in bits by format letter.
	localparam logic [5:0] LEN_A = 6'h30;
	localparam logic [5:0] LEN_B = 6'h20;
	localparam logic [5:0] LEN_C = 6'h10;

	// Universal register code space split: bit 6 set marks the complementary subset,
	// bit 5 is flipped to name a register's complement; bit 3 picks the generator that owns an index-group register.
	localparam int CPL_BIT = 6;
	localparam logic [UREG_W-1:0] CPL_FLIP = 7'h20;

	typedef enum logic [1:0] {
		IDM_FMT_A,
		IDM_FMT_B,
		IDM_FMT_C
	} idm_fmt_t;

	typedef enum logic [2:0] {
		IDM_OP_NONE,
		IDM_OP_PREMOD_RD,
		IDM_OP_PREMOD_WR,
		IDM_OP_IMM_MEM,
		IDM_OP_IMM_REG
	} idm_op_t;

	typedef struct packed {
		logic                   valid;
		idm_op_t                op;
		idm_fmt_t               fmt;
		logic                   pm_space;
		logic [IDX_SEL_W-1:0]   idx_sel;
		logic [IDX_SEL_W-1:0]   mod_sel;
		logic [UREG_W-1:0]      ureg;
		logic [IMM_W-1:0]       imm;
		logic                   long_word;
		logic                   reg40;
	} idm_instr_t;

	typedef struct packed {
		logic                   en;
		logic                   wr;
		logic                   pm_space;
		logic                   long_word;
		logic [ADDR_W-1:0]      addr;
		logic [WORD_W-1:0]      wdata;
	} idm_mem_t;

	typedef struct packed {
		logic                   en;
		logic [UREG_W-1:0]      sel;
		logic [WORD_W-1:0]      data;
	} idm_reg_t;

endpackage : idm_pkg

// ==== hw/idm_skew.sv ====
`timescale 1ns/1ps
module idm_skew
	import idm_pkg::*;
(
	input  wire logic                  simd_i,
	input  wire logic                  broadcast_i,
	input  wire logic                  short_word_i,
	input  wire logic [ADDR_W-1:0]     base_i,
	output logic      [ADDR_W-1:0]     y_addr_o
);

	logic [ADDR_W-1:0] k;

	always_comb begin
		if (!simd_i || broadcast_i) begin
			k = SKEW_BCAST; // [RULE9]
		end else if (short_word_i) begin
			k = SKEW_SHORT; // [RULE9]
		end else begin
			k = SKEW_NORMAL; // [RULE9]
		end
	end

	// Wraps modulo the address space on purpose.
	assign y_addr_o = base_i + k;

endmodule : idm_skew

// ==== tb/idm_props.sv ====
`timescale 1ns/1ps
module idm_props
	import idm_pkg::*;
(
	input wire logic		core_clk_i,
	input wire logic		rst_n_i,
	input wire logic		clk_en_i,
	input wire idm_instr_t		instr_i,
	input wire logic		simd_i,
	input wire logic		broadcast_i,
	input wire logic		short_word_i,
	input wire logic [ADDR_W-1:0]	index_data_i,
	input wire logic [ADDR_W-1:0]	modify_data_i,
	input wire idm_mem_t		mem_x_o,
	input wire idm_mem_t		mem_y_o,
	input wire idm_reg_t		reg_x_o,
	input wire idm_reg_t		reg_y_o,
	input wire logic		idx_wr_o,
	input wire logic [ADDR_W-1:0]	idx_wr_data_o,
	input wire logic [5:0]		instr_len_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Short forms carry only the low half, zero-extended.
	wire logic [IMM_W-1:0] imm_eff = (instr_i.fmt == IDM_FMT_A) ? instr_i.imm : {16'h0000, instr_i.imm[15:0]};
	wire logic cpl = instr_i.ureg[CPL_BIT];
	wire logic [ADDR_W-1:0] k = broadcast_i ? SKEW_BCAST : (short_word_i ? SKEW_SHORT : SKEW_NORMAL);
	sequence go(idm_op_t o);
		clk_en_i && instr_i.valid && instr_i.op == o ##1 clk_en_i;
	endsequence
	sequence pre;
		go(IDM_OP_PREMOD_RD) or go(IDM_OP_PREMOD_WR);
	endsequence
	premod_addr_a: assert property (pre |-> mem_x_o.en && mem_x_o.addr == $past(index_data_i) + $past(imm_eff))
		else $error("premod address wrong");
	premod_keep_a: assert property (pre |-> !idx_wr_o && mem_y_o.en == ($past(simd_i) && $past(cpl)))
		else $error("premod side effect wrong");
	y_skew_a: assert property (mem_y_o.en && $past(clk_en_i) |-> mem_x_o.en && mem_y_o.addr == mem_x_o.addr + $past(k))
		else $error("y skew wrong");
	mem_word_a: assert property (go(IDM_OP_IMM_MEM) |-> mem_x_o.wr && mem_x_o.wdata == {$past(imm_eff), 8'h00})
		else $error("memory word wrong");
	post_mod_a: assert property (go(IDM_OP_IMM_MEM) |-> mem_x_o.addr == $past(index_data_i) && idx_wr_o
		&& idx_wr_data_o == $past(index_data_i) + $past(modify_data_i)) else $error("post modify wrong");
	simd_mem_a: assert property (go(IDM_OP_IMM_MEM) ##0 $past(simd_i) |-> mem_y_o.en && mem_y_o.wdata == mem_x_o.wdata)
		else $error("y memory write missing");
	reg_cpl_a: assert property (go(IDM_OP_IMM_REG) ##0 $past(simd_i) && $past(cpl) |-> reg_y_o.en
		&& reg_y_o.sel == ($past(instr_i.ureg) ^ CPL_FLIP) && reg_y_o.data == reg_x_o.data) else $error("y reg wrong");
	lone_reg_a: assert property (go(IDM_OP_IMM_REG) ##0 !$past(cpl) |-> reg_x_o.en && !reg_y_o.en)
		else $error("lone reg wrong");
	instr_len_a: assert property (clk_en_i && instr_i.valid ##1 clk_en_i |-> instr_len_o ==
		($past(instr_i.fmt) == IDM_FMT_A ? LEN_A : ($past(instr_i.fmt) == IDM_FMT_B ? LEN_B : LEN_C)))
		else $error("length wrong");
endmodule : idm_props

bind idm_exec idm_props u_props (
	.core_clk_i    (core_clk_i),
	.rst_n_i       (rst_n_i),
	.clk_en_i      (clk_en_i),
	.instr_i       (instr_i),
	.simd_i        (simd_i),
	.broadcast_i   (broadcast_i),
	.short_word_i  (short_word_i),
	.index_data_i  (index_data_i),
	.modify_data_i (modify_data_i),
	.mem_x_o       (mem_x_o),
	.mem_y_o       (mem_y_o),
	.reg_x_o       (reg_x_o),
	.reg_y_o       (reg_y_o),
	.idx_wr_o      (idx_wr_o),
	.idx_wr_data_o (idx_wr_data_o),
	.instr_len_o   (instr_len_o)
);

// ==== tb/idm_regfile_model.sv ====
`timescale 1ns/1ps
module idm_regfile_model
	import idm_pkg::*;
(
	input wire logic		core_clk_i,
	input wire logic		rst_n_i,
	input wire idm_instr_t		instr_i,
	input wire logic		idx_wr_i,
	input wire logic [IDX_SEL_W-1:0]	idx_wr_sel_i,
	input wire logic		idx_wr_pm_i,
	input wire logic [ADDR_W-1:0]	idx_wr_data_i,
	output logic [ADDR_W-1:0]	index_o,
	output logic [ADDR_W-1:0]	modify_o
);
	logic [ADDR_W-1:0] idx_reg [2][8];
	assign index_o = idx_reg[instr_i.pm_space][instr_i.idx_sel];
	// Fixed modifiers keep the bench's expected addresses simple to derive.
	assign modify_o = {29'h0, instr_i.mod_sel} + 32'h0000_0010;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 16; i++) begin
				idx_reg[i/8][i%8] <= 32'h0000_1000 * i;
			end
		end else if (idx_wr_i) begin
			idx_reg[idx_wr_pm_i][idx_wr_sel_i] <= idx_wr_data_i;
		end
	end
endmodule : idm_regfile_model

// ==== tb/idm_bench.sv ====
`timescale 1ns/1ps
module immediate_data_move_execution_bench;
	import idm_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [2:0] mode = '0;
	logic clk_en = 1'b1;
	idm_instr_t instr = '0;
	logic [ADDR_W-1:0] idx, mdf, iwd;
	idm_mem_t mx, my;
	idm_reg_t rx, ry;
	logic iw, iwp, ill;
	logic [2:0] iws;
	logic [5:0] len;
	int fail_count = 0;
	int tests_run = 0;
	always #2.5 core_clk_i = ~core_clk_i;
	idm_exec DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .instr_i(instr),
		.simd_i(mode[2]), .broadcast_i(mode[1]), .short_word_i(mode[0]), .index_data_i(idx),
		.modify_data_i(mdf), .mem_x_o(mx), .mem_y_o(my), .reg_x_o(rx), .reg_y_o(ry), .idx_wr_o(iw),
		.idx_wr_sel_o(iws), .idx_wr_pm_o(iwp), .idx_wr_data_o(iwd), .instr_len_o(len), .illegal_o(ill));
	idm_regfile_model u_rf (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_i(instr), .idx_wr_i(iw),
		.idx_wr_sel_i(iws), .idx_wr_pm_i(iwp), .idx_wr_data_i(iwd), .index_o(idx), .modify_o(mdf));
	task automatic chk(input string n, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	// Legal scenarios keep register codes outside the index group; only the illegal-flag check breaks this.
	task automatic send(input idm_op_t op, input idm_fmt_t f, input logic pm, input logic [2:0] s,
		input logic [6:0] u, input logic [31:0] imm, input logic [2:0] m, input logic q = 1'b1);
		@(posedge core_clk_i);
		instr <= '{1'b1, op, f, pm, s, s, u, imm, q, q};
		mode <= m;
		@(posedge core_clk_i);
		instr <= '0;
		#1;
	endtask : send
	task automatic t_mem_post;
		send(IDM_OP_IMM_MEM, IDM_FMT_A, 1'b0, 3'h2, 7'h10, 32'hdead_beef, 3'b000);
		chk("x_addr", mx.addr, 32'h0000_2000);
		chk("x_data", mx.wdata, 40'hde_adbe_ef00);
		chk("idx_wr", {iw, iwp, iws, iwd}, {1'b1, 1'b0, 3'h2, 32'h0000_2012});
		chk("ill", ill, 1'b0);
		send(IDM_OP_IMM_MEM, IDM_FMT_B, 1'b0, 3'h2, 7'h10, 32'h1234_5678, 3'b000);
		chk("x_addr2", mx.addr, 32'h0000_2012);
		chk("short", mx.wdata, 40'h00_0056_7800);
		chk("len_b", len, 6'h20);
	endtask : t_mem_post
	task automatic t_skew;
		logic [31:0] k [3] = '{32'h0, 32'h2, 32'h1};
		for (int j = 0; j < 3; j++) begin
			send(IDM_OP_IMM_MEM, IDM_FMT_A, 1'b1, 3'(j + 3), 7'h10, 32'h0, {1'b1, j == 0, j == 1});
			chk("pair", {mx.en, my.en}, 2'b11);
			chk("y_addr", my.addr, 32'h0000_1000 * (j + 11) + k[j]);
			chk("idx_pm", {iw, iwp}, 2'b11);
		end
	endtask : t_skew
	task automatic t_premod;
		send(IDM_OP_PREMOD_RD, IDM_FMT_A, 1'b0, 3'h5, 7'h45, 32'hffff_fff0, 3'b100);
		chk("pre_x", mx.addr, 32'h0000_4ff0);
		chk("pre_y", my.addr, 32'h0000_4ff1);
		chk("pre_pair", {mx.en, my.en}, 2'b11);
		chk("keep", iw, 1'b0);
		chk("lw", mx.long_word, 1'b1);
		chk("ureg", rx.sel, 7'h45);
		chk("ry_sel", ry.sel, 7'h65);
		chk("len_a", len, 6'h30);
		send(IDM_OP_PREMOD_WR, IDM_FMT_C, 1'b1, 3'h0, 7'h10, 32'hffff_0004, 3'b100);
		chk("lone_y", {mx.en, my.en, mx.addr}, {2'b10, 32'h0000_8004});
		chk("len_c", len, 6'h10);
	endtask : t_premod
	task automatic t_reg;
		send(IDM_OP_IMM_REG, IDM_FMT_A, 1'b0, 3'h0, 7'h48, 32'h89ab_cdef, 3'b100);
		chk("rx", rx.data, 40'h89_abcd_ef00);
		chk("ry", {ry.en, ry.sel}, {1'b1, 7'h68});
		chk("ryd", ry.data, 40'h89_abcd_ef00);
		send(IDM_OP_IMM_REG, IDM_FMT_A, 1'b0, 3'h0, 7'h10, 32'h1, 3'b100);
		chk("lone", {rx.en, ry.en}, 2'b10);
	endtask : t_reg
	task automatic t_misc;
		send(IDM_OP_IMM_REG, IDM_FMT_B, 1'b0, 3'h0, 7'h48, 32'h1234_5678, 3'b000, 1'b0);
		chk("r32", rx.data, 40'h00_0000_5678);
		chk("r32_en", {rx.en, ry.en}, 2'b10);
		send(IDM_OP_PREMOD_RD, IDM_FMT_A, 1'b0, 3'h1, 7'h45, 32'h0000_0010, 3'b000, 1'b0);
		chk("sisd", {mx.en, my.en, mx.long_word, ill, mx.addr}, {4'b1000, 32'h0000_1010});
		send(IDM_OP_PREMOD_RD, IDM_FMT_A, 1'b0, 3'h1, 7'h03, 32'h0, 3'b000);
		chk("ill_gen", {ill, mx.en}, 2'b11);
	endtask : t_misc
	// A frozen enable must keep the last answer standing for one more cycle.
	task automatic t_freeze;
		@(posedge core_clk_i);
		instr <= '{1'b1, IDM_OP_IMM_REG, IDM_FMT_A, 1'b0, 3'h0, 3'h0, 7'h10, 32'h0000_00a5, 1'b1, 1'b1};
		@(posedge core_clk_i);
		instr <= '0;
		clk_en <= 1'b0;
		@(posedge core_clk_i);
		clk_en <= 1'b1;
		#1;
		chk("hold", {rx.en, rx.data[31:0]}, {1'b1, 32'h0000_a500});
		@(posedge core_clk_i);
		#1;
		chk("drop", rx.en, 1'b0);
	endtask : t_freeze
	task automatic report_and_stop;
		if (fail_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		t_mem_post();
		t_skew();
		t_premod();
		t_reg();
		t_misc();
		t_freeze();
		report_and_stop();
	end
endmodule : immediate_data_move_execution_bench
